// *** cmp_core_model.sv ***
/* Model of the analog cores and the Timer1 clock source.
   Levels come from the bench; runs on the block clock. */
module cmp_core_model (
	// Clock and controls
	input wire logic clk,
	input wire logic [1:0] core_enable,
	input wire logic [1:0] level,
	input wire logic tmr_run,
	// To the block
	output logic [1:0] raw_compare,
	output logic tmr_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div;
	// ==========================================
	// Off cores read low; timer clock stands high when stopped
	initial div = 2'h0;
	always @(posedge clk) begin
		div <= tmr_run ? div + 2'h1 : 2'h0;
	end
	assign raw_compare = core_enable & level;
	assign tmr_clk = ~div[1];
endmodule

// *** cmp_pkg.sv ***
/*
 * Package for the dual comparator control block: register offsets,
 * field positions, reset values and input select codes.
 * Assumes a byte-wide register port with 12-bit addresses.
 */
package cmp_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [11:0] OFS_CTRL0_CH1 = 12'h80c;
	localparam logic [11:0] OFS_CTRL1_CH1 = 12'h80d;
	localparam logic [11:0] OFS_NSEL_CH1 = 12'h80e;
	localparam logic [11:0] OFS_PSEL_CH1 = 12'h80f;
	localparam logic [11:0] OFS_CTRL0_CH2 = 12'h810;
	localparam logic [11:0] OFS_CTRL1_CH2 = 12'h811;
	localparam logic [11:0] OFS_NSEL_CH2 = 12'h812;
	localparam logic [11:0] OFS_PSEL_CH2 = 12'h813;
	localparam logic [11:0] OFS_COMBINED = 12'h81f;
	localparam logic [11:0] OFS_IRQ_CTRL = 12'h820;

	// ==========================================================
	// Field positions
	localparam int BIT_ENABLE = 7;
	localparam int BIT_RESULT = 6;
	localparam int BIT_INVERT = 4;
	localparam int BIT_SPEED = 2;
	localparam int BIT_HYST = 1;
	localparam int BIT_SYNC = 0;
	localparam int BIT_RISE = 1;
	localparam int BIT_FALL = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_CTRL0 = 8'h04;
	localparam logic [7:0] RST_CTRL1 = 8'h00;
	localparam logic [2:0] RST_SEL = 3'h0;

	// ==========================================================
	// Input select codes
	localparam logic [2:0] SEL_GROUND = 3'h7;
	localparam logic [2:0] SEL_FIXED_REF = 3'h6;
	localparam logic [2:0] SEL_DAC = 3'h4;
	localparam logic [2:0] SEL_PIN0 = 3'h0;

	// Route one-hot bit positions: pins 0..3, fixed ref, dac, ground
	localparam int ROUTE_FIXED_REF = 4;
	localparam int ROUTE_DAC = 5;
	localparam int ROUTE_GROUND = 6;

	// ADC trigger selection codes naming a comparator
	localparam logic [7:0] ADC_TRIG_CMP1 = 8'h1c;
	localparam logic [7:0] ADC_TRIG_CMP2 = 8'h1d;

	// Timer1 clock source kinds
	typedef enum logic [1:0] {
		TMR_SRC_SYSCLK,
		TMR_SRC_INSTCLK,
		TMR_SRC_OTHER
	} tmr_src_t;

endpackage

// *** dcc_asserts.sv ***
/* Checker for dual_comparator_control.
   Sees only the top module's ports; bound at the foot. */
module dcc_asserts
	import cmp_pkg::*;
(
	// Clock and bus
	input wire logic clk,
	input wire logic rst,
	input wire logic rd,
	input wire logic wr,
	input wire logic [7:0] rdata,
	// Context
	input wire logic sleep,
	input wire logic [7:0] adc_trigger_select,
	input wire logic [1:0] compare_irq_enable,
	input wire logic [1:0] compare_irq_clear,
	// Outputs
	input wire logic [1:0] core_enable,
	input wire logic [1:0] speed_power_select,
	input wire logic [1:0] hysteresis_enable,
	input wire logic [6:0] inverting_route_one,
	input wire logic [6:0] noninverting_route_one,
	input wire logic [1:0] compare_result,
	input wire logic [1:0] compare_irq_flag,
	input wire logic wake,
	input wire logic adc_trigger
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_trig_rise: assert property ($rose(compare_result[0]) && adc_trigger_select == ADC_TRIG_CMP1 |=> adc_trigger)
		else $error("no trigger");
	a_trig_pulse: assert property (adc_trigger |=> !adc_trigger)
		else $error("long trigger");
	a_flag_cause: assert property ($rose(compare_irq_flag[0]) |-> $past(compare_result[0]) != $past(compare_result[0], 2))
		else $error("flag without edge");
	a_flag_hold: assert property (compare_irq_flag[1] && !compare_irq_clear[1] |=> compare_irq_flag[1])
		else $error("flag lost");
	a_ctrl_write: assert property ($changed({core_enable, speed_power_select, hysteresis_enable})
		|-> $past(wr) || $past(wr, 2) || $past(wr, 3))
		else $error("control moved");
	a_route_off: assert property (!core_enable[0] && !$past(core_enable[0])
		|-> inverting_route_one == 7'h00 && noninverting_route_one == 7'h00)
		else $error("route while off");
	a_route_one: assert property ($onehot0(inverting_route_one) && $onehot0(noninverting_route_one))
		else $error("route not one-hot");
	a_rd_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("rdata not idle");
	a_wake_irq: assert property (sleep && |(compare_irq_flag & compare_irq_enable) |-> ##[0:2] wake)
		else $error("no wake");
	cover property ($rose(compare_irq_flag[0]));
	cover property (adc_trigger);
	cover property (wake);
endmodule

bind dual_comparator_control dcc_asserts dcc_asserts_i (.*);

// *** dual_comparator_control.sv ***
/*
 * Control and status logic for two analog comparator channels.
 * Assumes raw comparator bits, Timer1 clock and sleep flag are synchronous
 * or are resynchronised here; the analog compare lives outside.
 */
// Overview of operation
// - Channels run in sleep; flags wake device
// - Synchronised output stalls in sleep on sysclk
// - Rising result starts selected ADC conversion
// - Control bit 7 enables the channel
// - Control bit 6 reads polarity-adjusted result
// - Control bit 4 inverts the result
// - Control bit 2 selects low power, resets 1
// - Control bit 1 drives hysteresis enable
// - Sync mode updates on Timer1 falling edge
// - Rise enable sets flag on rising result
// - Fall enable sets flag on falling result
// - Inverting select routes ground, ref, pins
// - Noninverting select routes ground, ref, dac, pin
// - Small package drops absent pin routes
// - Combined register mirrors both results
// - Disabled channel disconnects inputs, result equals invert bit
// - Polarity toggle raises flag while disabled
// - Internal result relatched every cycle
module dual_comparator_control
	import cmp_pkg::*;
#(
	parameter bit SMALL_PACKAGE = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// System context
	input wire logic sleep,
	input wire logic [1:0] tmr_src,
	input wire logic tmr_clk,
	input wire logic [7:0] adc_trigger_select,
	input wire logic [1:0] compare_irq_enable,
	input wire logic [1:0] compare_irq_clear,
	// Analog cores
	input wire logic [1:0] raw_compare,
	output logic [1:0] core_enable,
	output logic [1:0] speed_power_select,
	output logic [1:0] hysteresis_enable,
	output logic [6:0] inverting_route_one,
	output logic [6:0] noninverting_route_one,
	output logic [6:0] inverting_route_two,
	output logic [6:0] noninverting_route_two,
	// Results and events
	output logic [1:0] compare_result,
	output logic [1:0] external_result,
	output logic [1:0] compare_irq_flag,
	output logic wake,
	output logic adc_trigger
);

	// ==========================================================
	// Decode functions
	function automatic logic [6:0] neg_route(input logic [2:0] sel, input logic en, input logic ch2);
		logic [6:0] r;
		r = 7'h00;
		if (en) begin
			unique case (sel)
				SEL_GROUND: r[ROUTE_GROUND] = 1'b1;
				SEL_FIXED_REF: r[ROUTE_FIXED_REF] = 1'b1;
				3'h3, 3'h2: r[sel[1:0]] = !SMALL_PACKAGE;
				3'h1: r[1] = !(SMALL_PACKAGE && ch2);
				SEL_PIN0: r[0] = 1'b1;
				default: r = 7'h00;
			endcase
		end
		return r;
	endfunction

	function automatic logic [6:0] pos_route(input logic [2:0] sel, input logic en, input logic ch2);
		logic [6:0] r;
		r = 7'h00;
		if (en) begin
			unique case (sel)
				SEL_GROUND: r[ROUTE_GROUND] = 1'b1;
				SEL_FIXED_REF: r[ROUTE_FIXED_REF] = 1'b1;
				SEL_DAC: r[ROUTE_DAC] = 1'b1;
				SEL_PIN0: r[0] = !(SMALL_PACKAGE && ch2);
				default: r = 7'h00;
			endcase
		end
		return r;
	endfunction

	// ==========================================================
	// Registers
	logic [1:0] enable, invert, speed, hyst, sync_mode, rise_en, fall_en;
	logic [2:0] nsel [2];
	logic [2:0] psel [2];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 2; i++) begin
				enable[i] <= RST_CTRL0[BIT_ENABLE];
				invert[i] <= RST_CTRL0[BIT_INVERT];
				speed[i] <= RST_CTRL0[BIT_SPEED];
				hyst[i] <= RST_CTRL0[BIT_HYST];
				sync_mode[i] <= RST_CTRL0[BIT_SYNC];
				rise_en[i] <= RST_CTRL1[BIT_RISE];
				fall_en[i] <= RST_CTRL1[BIT_FALL];
				nsel[i] <= RST_SEL;
				psel[i] <= RST_SEL;
			end
		end else if (wr) begin
			unique case (addr)
				OFS_CTRL0_CH1, OFS_CTRL0_CH2: begin
					enable[addr == OFS_CTRL0_CH2] <= wdata[BIT_ENABLE];
					invert[addr == OFS_CTRL0_CH2] <= wdata[BIT_INVERT];
					speed[addr == OFS_CTRL0_CH2] <= wdata[BIT_SPEED];
					hyst[addr == OFS_CTRL0_CH2] <= wdata[BIT_HYST];
					sync_mode[addr == OFS_CTRL0_CH2] <= wdata[BIT_SYNC];
				end
				OFS_CTRL1_CH1, OFS_CTRL1_CH2: begin
					rise_en[addr == OFS_CTRL1_CH2] <= wdata[BIT_RISE];
					fall_en[addr == OFS_CTRL1_CH2] <= wdata[BIT_FALL];
				end
				OFS_NSEL_CH1: nsel[0] <= wdata[2:0];
				OFS_NSEL_CH2: nsel[1] <= wdata[2:0];
				OFS_PSEL_CH1: psel[0] <= wdata[2:0];
				OFS_PSEL_CH2: psel[1] <= wdata[2:0];
				OFS_IRQ_CTRL: begin
					rise_en <= {wdata[3], wdata[1]};
					fall_en <= {wdata[2], wdata[0]};
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Analog controls
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_enable <= 2'b00;
			speed_power_select <= {2{RST_CTRL0[BIT_SPEED]}};
			hysteresis_enable <= 2'b00;
			inverting_route_one <= 7'h00;
			noninverting_route_one <= 7'h00;
			inverting_route_two <= 7'h00;
			noninverting_route_two <= 7'h00;
		end else begin
			core_enable <= enable;
			speed_power_select <= speed;
			hysteresis_enable <= hyst;
			inverting_route_one <= neg_route(nsel[0], enable[0], 1'b0);
			noninverting_route_one <= pos_route(psel[0], enable[0], 1'b0);
			inverting_route_two <= neg_route(nsel[1], enable[1], 1'b1);
			noninverting_route_two <= pos_route(psel[1], enable[1], 1'b1);
		end
	end

	// ==========================================================
	// Synchronisers: raw compare and Timer1 clock
	logic [1:0] raw_meta, raw_sync;
	logic tmr_meta, tmr_sync, tmr_prev;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			raw_meta <= 2'b00;
			raw_sync <= 2'b00;
			tmr_meta <= 1'b0;
			tmr_sync <= 1'b0;
			tmr_prev <= 1'b0;
		end else begin
			raw_meta <= raw_compare;
			raw_sync <= raw_meta;
			tmr_meta <= tmr_clk;
			tmr_sync <= tmr_meta;
			tmr_prev <= tmr_sync;
		end
	end

	// ==========================================================
	// Result, synchronous latch, edges
	logic [1:0] next_result;
	logic [1:0] result_prev;
	logic tmr_fall, tmr_runs;

	assign next_result = (raw_sync & enable) ^ invert;
	assign tmr_fall = tmr_prev && !tmr_sync;
	assign tmr_runs = !(sleep && (tmr_src == TMR_SRC_SYSCLK || tmr_src == TMR_SRC_INSTCLK));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_result <= 2'b00;
			result_prev <= 2'b00;
		end else begin
			compare_result <= next_result;
			result_prev <= compare_result;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			external_result <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!sync_mode[i]) begin
					external_result[i] <= next_result[i];
				end else if (tmr_fall && tmr_runs) begin
					external_result[i] <= next_result[i];
				end
			end
		end
	end

	// ==========================================================
	// Interrupt flags, wake and ADC trigger
	logic [1:0] rise, fall;

	assign rise = compare_result & ~result_prev;
	assign fall = ~compare_result & result_prev;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_irq_flag <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((rise[i] && rise_en[i]) || (fall[i] && fall_en[i])) begin
					compare_irq_flag[i] <= 1'b1;
				end else if (compare_irq_clear[i]) begin
					compare_irq_flag[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake <= 1'b0;
		end else begin
			wake <= sleep && |(compare_irq_flag & compare_irq_enable);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			adc_trigger <= 1'b0;
		end else begin
			adc_trigger <= (adc_trigger_select == ADC_TRIG_CMP1 && rise[0])
				|| (adc_trigger_select == ADC_TRIG_CMP2 && rise[1]);
		end
	end

	// ==========================================================
	// Read port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			unique case (addr)
				OFS_CTRL0_CH1, OFS_CTRL0_CH2: begin
					rdata <= {enable[addr == OFS_CTRL0_CH2], compare_result[addr == OFS_CTRL0_CH2], 1'b0,
						invert[addr == OFS_CTRL0_CH2], 1'b0, speed[addr == OFS_CTRL0_CH2],
						hyst[addr == OFS_CTRL0_CH2], sync_mode[addr == OFS_CTRL0_CH2]};
				end
				OFS_CTRL1_CH1: rdata <= {6'h00, rise_en[0], fall_en[0]};
				OFS_CTRL1_CH2: rdata <= {6'h00, rise_en[1], fall_en[1]};
				OFS_NSEL_CH1: rdata <= {5'h00, nsel[0]};
				OFS_NSEL_CH2: rdata <= {5'h00, nsel[1]};
				OFS_PSEL_CH1: rdata <= {5'h00, psel[0]};
				OFS_PSEL_CH2: rdata <= {5'h00, psel[1]};
				OFS_COMBINED: rdata <= {6'h00, compare_result};
				OFS_IRQ_CTRL: rdata <= {4'h0, rise_en[1], fall_en[1], rise_en[0], fall_en[0]};
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule

// *** tb_top.sv ***
/* Testbench for dual_comparator_control with the core model.
   Inputs are driven by non-blocking assignment at the rising edge. */
module tb_top
	import cmp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sleep = 1'b0, tmr_run = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0] wdata = 8'h00, rdata, adc_sel = ADC_TRIG_CMP1;
	logic [1:0] tmr_src = 2'h2, irq_en = 2'h0, irq_clr = 2'h0, level = 2'h0;
	logic [1:0] raw, core_en, res, ext, flag;
	logic tclk, wake, trig;
	logic [6:0] nr1, pr1, nr2, pr2;
	logic [1:0] sp, hy;
	int bad_count = 0, num_checks = 0, trigs = 0;
	dual_comparator_control dual_comparator_control_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep), .tmr_src(tmr_src), .tmr_clk(tclk),
		.adc_trigger_select(adc_sel), .compare_irq_enable(irq_en), .compare_irq_clear(irq_clr),
		.raw_compare(raw), .core_enable(core_en), .speed_power_select(sp), .hysteresis_enable(hy),
		.inverting_route_one(nr1), .noninverting_route_one(pr1), .inverting_route_two(nr2),
		.noninverting_route_two(pr2), .compare_result(res), .external_result(ext),
		.compare_irq_flag(flag), .wake(wake), .adc_trigger(trig));
	cmp_core_model cmp_core_model_i (.clk(clk), .core_enable(core_en), .level(level),
		.tmr_run(tmr_run), .raw_compare(raw), .tmr_clk(tclk));
	// ==========================================
	// Helpers
	initial forever #20 clk = ~clk;
	always @(posedge clk) if (trig) trigs++;
	task automatic chk(input logic [7:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	task automatic lvl(input logic [1:0] v);
		@(posedge clk);
		level <= v;
		repeat (12) @(posedge clk);
		@(negedge clk);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset;
		rreg(OFS_CTRL0_CH1, 8'h04);
		rreg(OFS_CTRL1_CH2, 8'h00);
		rreg(12'h900, 8'h00);
		chk(8'({sp, hy}), 8'h0c);
	endtask
	task automatic t_polarity;
		wreg(OFS_CTRL0_CH1, 8'hc0);
		lvl(2'h0);
		rreg(OFS_CTRL0_CH1, 8'h80);
		lvl(2'h1);
		rreg(OFS_CTRL0_CH1, 8'hc0);
		rreg(OFS_COMBINED, 8'h01);
		chk(8'(trigs), 8'h01);
		wreg(OFS_CTRL0_CH1, 8'h90);
		lvl(2'h1);
		rreg(OFS_COMBINED, 8'h00);
	endtask
	task automatic t_edges;
		wreg(OFS_CTRL1_CH1, 8'h02);
		sleep <= 1'b1;
		irq_en <= 2'h1;
		lvl(2'h0);
		chk(8'({wake, flag[0]}), 8'h03);
		@(posedge clk);
		irq_clr <= 2'h1;
		@(posedge clk);
		irq_clr <= 2'h0;
		lvl(2'h1);
		chk(8'(flag[0]), 8'h00);
		wreg(OFS_CTRL1_CH1, 8'h01);
		lvl(2'h0);
		chk(8'(flag[0]), 8'h00);
		lvl(2'h1);
		chk(8'(flag[0]), 8'h01);
	endtask
	task automatic t_disabled;
		rreg(OFS_COMBINED, 8'h00);
		wreg(OFS_CTRL1_CH2, 8'h02);
		wreg(OFS_CTRL0_CH2, 8'h16);
		lvl(2'h1);
		chk(8'(flag[1]), 8'h01);
		chk(8'({sp, hy}), 8'h0a);
		chk(8'(nr2 | pr2), 8'h00);
		rreg(OFS_COMBINED, 8'h02);
	endtask
	task automatic t_routes;
		logic [6:0] g;
		for (int i = 0; i < 8; i++) begin
			wreg(OFS_NSEL_CH1, 8'(i));
			wreg(OFS_PSEL_CH1, 8'(i));
			repeat (3) @(negedge clk);
			g = i == 6 ? 7'h10 : i == 7 ? 7'h40 : 7'h00;
			chk(8'(nr1), i < 4 ? 8'(1 << i) : 8'(g));
			chk(8'(pr1), i == 0 ? 8'h01 : i == 4 ? 8'h20 : 8'(g));
		end
	endtask
	task automatic t_sync;
		wreg(OFS_CTRL0_CH1, 8'h81);
		lvl(2'h1);
		chk(8'({ext[0], res[0]}), 8'h01);
		@(posedge clk);
		tmr_run <= 1'b1;
		lvl(2'h1);
		chk(8'(ext[0]), 8'h01);
		@(posedge clk);
		tmr_src <= 2'h0;
		lvl(2'h0);
		chk(8'(ext[0]), 8'h01);
		@(posedge clk);
		sleep <= 1'b0;
		lvl(2'h0);
		chk(8'(ext[0]), 8'h00);
	endtask
	task automatic stop_test;
		$display("checks=%0d errors=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_polarity;
		t_edges;
		t_disabled;
		t_routes;
		t_sync;
		stop_test;
	end
	initial begin
		#200us;
		bad_count++;
		stop_test;
	end
endmodule
